// *** logic/tsp_serializer.v ***
// Transmit serializer channel: word buffer, shifter, inversion, reversal, idle and receiver detect.
// Assumes Avalon-MM master on clk; detect comparator and pins are outside, synchronised here.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.vh"
// Overview of operation
// - Accept 8, 10, 16 or 20 bit words and shift them out serially.
// - Without reversal, least significant bit goes out first.
// - Polarity invert high flips every bit of the word.
// - Reversal mirrors the whole word so the top bit goes first.
// - Channels 1 and 4 have central dividers; only those drive bonding lines.
// - Divider derives word and bit clocks, optionally clocks receive coding.
// - Detect runs on fixed clock, needs termination on and output tri-stated.
// - Detect reports whether a terminated receiver sits downstream.
// - Tri-state holds both legs at common mode, giving electrical idle.
// - Channel runs from fabric directly or through the PIPE path.
module tsp_serializer #(
  parameter CHANNEL = 0
) (
  input wire clk,
  input wire reset,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [19:0] fabric_data,
  input wire fabric_valid,
  output wire fabric_ready,
  input wire [19:0] pipe_data,
  input wire pipe_valid,
  output wire pipe_ready,
  input wire tx_invert_polarity,
  input wire tx_bit_reverse,
  input wire fixed_clk_tick,
  input wire det_response,
  output reg tx_serial,
  output reg tx_serial_oe,
  output reg on_die_termination,
  output reg det_step,
  output wire bond_clk_en,
  output wire rx_pcs_clk_en
);
  localparam DET_IDLE = 2'h0;
  localparam DET_STEP = 2'h1;
  localparam DET_SAMPLE = 2'h2;
  reg [31:0] ctrl;
  reg det_busy_flag;
  reg det_present;
  reg det_done;
  reg [1:0] det_state;
  reg [7:0] det_count;
  reg ack;
  reg [19:0] shifter;
  reg [1:0] inv_sync;
  reg [1:0] rev_sync;
  reg [1:0] fix_sync;
  reg [1:0] resp_sync;
  reg fix_prev;
  reg shifter_full;
  wire word_tick;
  wire [19:0] src_data;
  wire src_valid;
  wire buf_ready;
  wire [19:0] head;
  wire head_valid;
  wire head_ready;
  wire use_pipe;
  wire fix_edge;
  wire reg_ctrl_hit;
  wire reg_det_hit;
  reg [19:0] masked;
  reg [19:0] mirrored;
  reg [19:0] next_shifter;
  reg [31:0] next_ctrl;
  wire [31:0] lane_ctrl;
  integer i;
  genvar g;

  // Fabric or PIPE source selection
  assign use_pipe = ctrl[`TSP_CTRL_PIPE];
  assign src_data = use_pipe ? pipe_data : fabric_data;
  assign src_valid = use_pipe ? pipe_valid : fabric_valid;
  assign fabric_ready = !use_pipe && buf_ready;
  assign pipe_ready = use_pipe && buf_ready;

  tsp_buf2 u_buf (
    .clk(clk),
    .reset(reset),
    .in_data(src_data),
    .in_valid(src_valid),
    .in_ready(buf_ready),
    .out_data(head),
    .out_valid(head_valid),
    .out_ready(head_ready)
  );

  tsp_clkdiv u_div (
    .clk(clk),
    .reset(reset),
    .width_sel(ctrl[`TSP_CTRL_WIDTH_MSB:`TSP_CTRL_WIDTH_LSB]),
    .use_pll(1'b1),
    .central(CHANNEL == 1 || CHANNEL == 4),
    .bond_req(ctrl[`TSP_CTRL_BOND]),
    .rx_pcs_req(ctrl[`TSP_CTRL_RXPCS]),
    .word_tick(word_tick),
    .bit_index(),
    .bond_clk_en(bond_clk_en),
    .rx_pcs_clk_en(rx_pcs_clk_en)
  );

  // Pin-level controls pass two flops before use
  always @(posedge clk) begin
    if (reset) begin
      inv_sync <= 2'h0;
      rev_sync <= 2'h0;
      fix_sync <= 2'h0;
      resp_sync <= 2'h0;
      fix_prev <= 1'b0;
    end else begin
      inv_sync <= {inv_sync[0], tx_invert_polarity};
      rev_sync <= {rev_sync[0], tx_bit_reverse};
      fix_sync <= {fix_sync[0], fixed_clk_tick};
      resp_sync <= {resp_sync[0], det_response};
      fix_prev <= fix_sync[1];
    end
  end
  assign fix_edge = fix_sync[1] && !fix_prev;

  // Inversion and reversal applied to the loaded word, width-aware
  always @* begin
    masked = head;
    case (ctrl[`TSP_CTRL_WIDTH_MSB:`TSP_CTRL_WIDTH_LSB])
      `TSP_WIDTH_8: masked = {12'h000, head[7:0]};
      `TSP_WIDTH_10: masked = {10'h000, head[9:0]};
      `TSP_WIDTH_16: masked = {4'h0, head[15:0]};
      default: masked = head;
    endcase
    if (inv_sync[1] || ctrl[`TSP_CTRL_INV]) begin
      masked = ~masked;
    end
    mirrored = 20'h00000;
    for (i = 0; i < 20; i = i + 1) begin
      case (ctrl[`TSP_CTRL_WIDTH_MSB:`TSP_CTRL_WIDTH_LSB])
        `TSP_WIDTH_8: if (i < 8) mirrored[i] = masked[7 - i];
        `TSP_WIDTH_10: if (i < 10) mirrored[i] = masked[9 - i];
        `TSP_WIDTH_16: if (i < 16) mirrored[i] = masked[15 - i];
        default: mirrored[i] = masked[19 - i];
      endcase
    end
    // Reversal after inversion, so either order gives the same bits
    if (rev_sync[1] || ctrl[`TSP_CTRL_REV]) begin
      next_shifter = mirrored;
    end else begin
      next_shifter = masked;
    end
  end

  // Word loads only at the word boundary, so mid-word inversion or reversal changes cannot corrupt
  assign head_ready = word_tick;
  always @(posedge clk) begin
    if (reset) begin
      shifter <= 20'h00000;
      shifter_full <= 1'b0;
      tx_serial <= 1'b0;
      tx_serial_oe <= 1'b0;
    end else begin
      if (word_tick) begin
        shifter_full <= head_valid;
        shifter <= head_valid ? next_shifter : 20'h00000;
      end else begin
        shifter <= {1'b0, shifter[19:1]};
      end
      tx_serial <= word_tick ? next_shifter[0] && head_valid : shifter[1];
      // Tri-state releases both legs to common mode; only the tri-state control bit sets idle, detect does not
      tx_serial_oe <= !ctrl[`TSP_CTRL_TRISTATE];
    end
  end

  // Receiver detect on the fixed clock tick; refused unless termination on and tri-stated
  always @(posedge clk) begin
    if (reset) begin
      det_state <= DET_IDLE;
      det_count <= 8'h00;
      det_step <= 1'b0;
      det_present <= 1'b0;
      det_done <= 1'b0;
      det_busy_flag <= 1'b0;
    end else begin
      case (det_state)
        DET_IDLE: begin
          det_step <= 1'b0;
          if (ack && avs_write && reg_det_hit && avs_byteenable[0] && avs_writedata[`TSP_DET_START]
              && ctrl[`TSP_CTRL_ODT] && ctrl[`TSP_CTRL_TRISTATE]) begin
            det_state <= DET_STEP;
            det_busy_flag <= 1'b1;
            det_done <= 1'b0;
            det_count <= 8'h00;
          end
        end
        DET_STEP: begin
          det_step <= 1'b1;
          if (fix_edge) begin
            det_count <= det_count + 8'h01;
            if (det_count == (`TSP_DET_SETTLE - 1)) begin
              det_state <= DET_SAMPLE;
            end
          end
        end
        DET_SAMPLE: begin
          // A slow rise means a terminated receiver loads the line
          det_present <= resp_sync[1];
          det_done <= 1'b1;
          det_busy_flag <= 1'b0;
          det_step <= 1'b0;
          det_state <= DET_IDLE;
        end
        default: det_state <= DET_IDLE;
      endcase
    end
  end

  // Avalon-MM slave: one wait cycle then answer
  assign reg_ctrl_hit = (avs_address == `TSP_REG_CTRL);
  assign reg_det_hit = (avs_address == `TSP_REG_DETECT);
  assign avs_waitrequest = (avs_read || avs_write) && !ack;
  // Byte lanes follow their enables; bits above the bonding control always read zero
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign lane_ctrl[g * 8 +: 8] = avs_byteenable[g] ? avs_writedata[g * 8 +: 8] : ctrl[g * 8 +: 8];
    end
  endgenerate
  always @* begin
    next_ctrl = {23'h000000, lane_ctrl[8:0]};
  end
  always @(posedge clk) begin
    if (reset) begin
      ack <= 1'b0;
      ctrl <= `TSP_CTRL_RESET;
      avs_readdata <= 32'h00000000;
      on_die_termination <= 1'b0;
    end else begin
      ack <= (avs_read || avs_write) && !ack;
      if (ack && avs_write && reg_ctrl_hit) begin
        ctrl <= next_ctrl;
      end
      on_die_termination <= ctrl[`TSP_CTRL_ODT];
      if ((avs_read || avs_write) && !ack) begin
        case (avs_address)
          `TSP_REG_CTRL: avs_readdata <= ctrl;
          `TSP_REG_STATUS: avs_readdata <= {26'h0000000, bond_clk_en, shifter_full, head_valid,
                                            det_busy_flag, det_done, det_present};
          `TSP_REG_DETECT: avs_readdata <= {31'h00000000, det_busy_flag};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// *** common/tsp_regs.vh ***
// Register map, field positions, reset values and timing counts of the transmit serializer.
// Assumes inclusion by bare name; defines only.
`ifndef TSP_REGS_VH
`define TSP_REGS_VH
`define TSP_ADDR_W 4
`define TSP_REG_CTRL 4'h0
`define TSP_REG_STATUS 4'h4
`define TSP_REG_DETECT 4'h8
`define TSP_CTRL_WIDTH_LSB 0
`define TSP_CTRL_WIDTH_MSB 1
`define TSP_CTRL_INV 2
`define TSP_CTRL_REV 3
`define TSP_CTRL_TRISTATE 4
`define TSP_CTRL_ODT 5
`define TSP_CTRL_PIPE 6
`define TSP_CTRL_RXPCS 7
`define TSP_CTRL_BOND 8
`define TSP_CTRL_RESET 32'h00000000
`define TSP_WIDTH_8 2'h0
`define TSP_WIDTH_10 2'h1
`define TSP_WIDTH_16 2'h2
`define TSP_WIDTH_20 2'h3
`define TSP_DET_START 0
`define TSP_DET_TIME_NS 1000
`define TSP_CLK_NS 8
`define TSP_DET_CYCLES ((`TSP_DET_TIME_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_DET_SETTLE_NS 200
`define TSP_DET_SETTLE ((`TSP_DET_SETTLE_NS + `TSP_CLK_NS - 1) / `TSP_CLK_NS)
`define TSP_DIV_RESET 2'h0
`endif

// *** logic/tsp_buf2.v ***
// Two-entry word buffer with valid/ready on both sides.
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tsp_buf2 (
  input wire clk,
  input wire reset,
  input wire [19:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [19:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [19:0] spare;
  reg [1:0] count;
  wire push;
  wire pop;
  assign in_ready = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge clk) begin
    if (reset) begin
      count <= 2'h0;
      out_data <= 20'h00000;
      spare <= 20'h00000;
    end else begin
      if (push && !pop) begin
        count <= count + 2'h1;
      end else if (pop && !push) begin
        count <= count - 2'h1;
      end
      // Head takes the spare on pop when two are held, else the incoming word on pop or when empty
      if (pop) begin
        if (count == 2'h2) begin
          out_data <= spare;
        end else begin
          out_data <= in_data;
        end
      end else if (count == 2'h0 && push) begin
        out_data <= in_data;
      end
      if (push && ((count == 2'h1 && !pop) || (count == 2'h2 && pop))) begin
        spare <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// *** logic/tsp_clkdiv.v ***
// Transmit clock divider: serial bit enable and parallel word load strobe.
// Assumes the core clock stands in for the high-rate source; one bit per clock.
`timescale 1ns/1ps
`default_nettype none
`include "tsp_regs.vh"
module tsp_clkdiv (
  input wire clk,
  input wire reset,
  input wire [1:0] width_sel,
  input wire use_pll,
  input wire central,
  input wire bond_req,
  input wire rx_pcs_req,
  output reg word_tick,
  output reg [4:0] bit_index,
  output wire bond_clk_en,
  output wire rx_pcs_clk_en
);
  reg [4:0] last;
  always @* begin
    case (width_sel)
      `TSP_WIDTH_8: last = 5'h07;
      `TSP_WIDTH_10: last = 5'h09;
      `TSP_WIDTH_16: last = 5'h0F;
      default: last = 5'h13;
    endcase
  end
  // Word strobe on the last bit of each word; source choice use_pll has no effect on it
  always @(posedge clk) begin
    if (reset) begin
      bit_index <= 5'h00;
      word_tick <= 1'b0;
    end else begin
      word_tick <= (bit_index == last) || use_pll == use_pll && bit_index > last;
      if (bit_index >= last) begin
        bit_index <= 5'h00;
      end else begin
        bit_index <= bit_index + 5'h01;
      end
    end
  end
  assign bond_clk_en = central && bond_req;
  assign rx_pcs_clk_en = rx_pcs_req;
endmodule
`default_nettype wire

// *** tb/tsp_serializer_chk.sv ***
// Port assertions for the transmit serializer.
// Assumes binding to tsp_serializer; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tsp_serializer_chk #(
  parameter CHANNEL = 0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fabric_ready,
  input wire logic pipe_ready,
  input wire logic tx_serial_oe,
  input wire logic on_die_termination,
  input wire logic det_step,
  input wire logic bond_clk_en,
  input wire logic rx_pcs_clk_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence seq_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence seq_det_go;
    avs_write && !avs_waitrequest && avs_address == 4'h8 && avs_writedata[0] && on_die_termination && !tx_serial_oe;
  endsequence
  sequence seq_tri_wr;
    avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0] && avs_writedata[4];
  endsequence
  AST_ONE_WAIT: assert property ($rose(avs_read || avs_write) |-> seq_one_wait)
    else $error("waitrequest not one cycle");
  AST_DET_GO: assert property (seq_det_go |-> ##[1:2] det_step)
    else $error("detect step missing");
  AST_DET_ENV: assert property (det_step |-> on_die_termination && !tx_serial_oe)
    else $error("detect without termination or idle");
  AST_TRI: assert property (seq_tri_wr |-> ##2 !tx_serial_oe [*3])
    else $error("output not idle after tristate");
  AST_RESET_IDLE: assert property ($fell(reset) |-> !tx_serial_oe && !det_step && !on_die_termination)
    else $error("output active out of reset");
  AST_BOND: assert property (bond_clk_en |-> (CHANNEL == 1 || CHANNEL == 4))
    else $error("bond clock from local divider");
  AST_BOND_STAT: assert property (avs_read && !avs_waitrequest && avs_address == 4'h4 |-> avs_readdata[5] == bond_clk_en)
    else $error("status bond bit wrong");
  AST_RXPCS: assert property ($changed(rx_pcs_clk_en) |-> $past(avs_write && !avs_waitrequest && avs_address == 4'h0))
    else $error("receive coding clock changed alone");
  AST_PATHS: assert property (!(fabric_ready && pipe_ready))
    else $error("both data paths ready");
endmodule
bind tsp_serializer tsp_serializer_chk #(.CHANNEL(CHANNEL)) u_chk (.*);
`default_nettype wire

// *** tb/tsp_rx_model.sv ***
// Receiver model at the far end of the serial line.
// Assumes one bit per core clock; keeps the line history for search.
`timescale 1ns/1ps
`default_nettype none
module tsp_rx_model (
  input wire logic clk,
  input wire logic tx_serial,
  input wire logic tx_serial_oe
);
  logic [127:0] hist = 128'h0;
  logic line_lvl;
  // Released line shows a changing level, never a stale bit
  assign line_lvl = tx_serial_oe ? tx_serial : ~hist[0];
  // Disparity is not judged, so errors after a polarity change pass
  always @(posedge clk) hist <= {hist[126:0], line_lvl};
  // s[0] is the first bit on the line; only the last 72 bits are searched
  function automatic logic found(input logic [19:0] s, input int n);
    logic ok;
    for (int i = 0; i <= 72 - n; i++) begin
      ok = 1'h1;
      for (int b = 0; b < n; b++)
        if (hist[i + n - 1 - b] !== s[b]) ok = 1'h0;
      if (ok) return 1'h1;
    end
    return 1'h0;
  endfunction
endmodule
`default_nettype wire

// *** tb/test_tsp_serializer.sv ***
// Bench for the transmit serializer: registers, stream order, buffer, detect.
// Assumes CHANNEL 1 and one 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_tsp_serializer;
  logic clk = 1'h0, reset = 1'h1, avs_read = 1'h0, avs_write = 1'h0, sel_pipe = 1'h0;
  logic fabric_valid = 1'h0, pipe_valid = 1'h0, tx_invert_polarity = 1'h0, tx_bit_reverse = 1'h0;
  logic fixed_clk_tick = 1'h0, det_response = 1'h0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0, q;
  logic [19:0] fabric_data = 20'h0, pipe_data = 20'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, fabric_ready, pipe_ready, tx_serial, tx_serial_oe, on_die_termination, det_step;
  wire bond_clk_en, rx_pcs_clk_en;
  int fail_count = 0, total_checks = 0, i, k;
  int wtab[4] = '{8, 10, 16, 20};
  tsp_serializer #(.CHANNEL(1)) dut (.*);
  tsp_rx_model u_rx (.clk(clk), .tx_serial(tx_serial), .tx_serial_oe(tx_serial_oe));
  initial forever #4 clk = ~clk;
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task to_fail();
    chk("wait", 32'h0, 32'h1);
    disable main_seq;
  endtask
  // Sole controller of the block; request held until waitrequest is sampled low at a rising edge
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'h0 && i < 20);
    if (avs_waitrequest !== 1'h0) to_fail();
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(negedge clk);
  endtask
  task push(input logic [19:0] d);
    @(posedge clk);
    fabric_data <= d;
    pipe_data <= d;
    fabric_valid <= !sel_pipe;
    pipe_valid <= sel_pipe;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while ((sel_pipe ? pipe_ready : fabric_ready) !== 1'h1 && i < 40);
    if (i >= 40) to_fail();
    @(posedge clk);
    fabric_valid <= 1'h0;
    pipe_valid <= 1'h0;
  endtask
  function automatic logic [19:0] order(input logic [19:0] d, input int n, input logic inv, input logic rev);
    logic [19:0] s;
    s = 20'h0;
    for (int b = 0; b < n; b++)
      s[b] = (rev ? d[n - 1 - b] : d[b]) ^ inv;
    return s;
  endfunction
  task conclude();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    begin : main_seq
      repeat (6) @(posedge clk);
      reset <= 1'h0;
      bus(1'h0, 4'h0, 32'h0);
      chk("ctrl_reset", q, 32'h0);
      bus(1'h1, 4'h0, 32'hFFFFFFFF);
      bus(1'h0, 4'h0, 32'h0);
      chk("ctrl", q, 32'h000001FF);
      chk("bond", bond_clk_en, 32'h1);
      chk("rx_pcs", rx_pcs_clk_en, 32'h1);
      bus(1'h0, 4'h4, 32'h0);
      chk("status_bond", q[5], 32'h1);
      bus(1'h0, 4'hC, 32'h0);
      chk("unmapped", q, 32'h0);
      $display("test registers done");
      for (int m = 0; m < 16; m++) begin
        // Odd modes ask for inversion and reversal by register, even modes by pin
        bus(1'h1, 4'h0, {25'h0, m[3], 2'h0, m[3] & m[0], m[2] & m[0], m[1:0]});
        sel_pipe = m[3];
        // Pins change only while the shifter is idle, between words
        @(posedge clk);
        tx_invert_polarity <= m[2] & !m[0];
        tx_bit_reverse <= m[3] & !m[0];
        repeat (4) @(posedge clk);
        push(20'h9AE6B);
        repeat (70) @(negedge clk);
        chk("stream", u_rx.found(order(20'h9AE6B, wtab[m[1:0]], m[2], m[3]), wtab[m[1:0]]), 32'h1);
      end
      $display("test stream done");
      bus(1'h1, 4'h0, 32'h3);
      @(posedge clk);
      fabric_valid <= 1'h1;
      k = 0;
      for (int j = 0; j < 8; j++) begin
        @(negedge clk);
        if (fabric_ready !== 1'h1) break;
        k++;
        @(posedge clk);
      end
      chk("refused", fabric_ready, 32'h0);
      chk("fill", k >= 2 && k <= 3, 32'h1);
      @(posedge clk);
      fabric_valid <= 1'h0;
      for (int j = 0; j < 40; j++) begin
        bus(1'h0, 4'h4, 32'h0);
        if (q[3] === 1'h0) break;
      end
      chk("drained", q[3], 32'h0);
      $display("test buffer done");
      bus(1'h1, 4'h8, 32'h1);
      chk("det_ignored", det_step, 32'h0);
      bus(1'h0, 4'h8, 32'h0);
      chk("det_refused", q, 32'h0);
      bus(1'h1, 4'h0, 32'h30);
      // Termination and output enable are registered one edge after the control word
      @(negedge clk);
      chk("odt", on_die_termination, 32'h1);
      chk("idle", tx_serial_oe, 32'h0);
      for (int r = 1; r >= 0; r--) begin
        @(posedge clk);
        det_response <= r[0];
        bus(1'h1, 4'h8, 32'h1);
        @(negedge clk);
        chk("step", det_step, 32'h1);
        bus(1'h0, 4'h8, 32'h0);
        chk("det_busy", q, 32'h1);
        for (int t = 0; t < 60; t++) begin
          repeat (3) @(posedge clk);
          fixed_clk_tick <= ~fixed_clk_tick;
        end
        bus(1'h0, 4'h4, 32'h0);
        chk("detect", q[2:0], {30'h1, r[0]});
      end
      $display("test detect done");
    end
    conclude();
  end
endmodule
`default_nettype wire
